// [hdl/acsc_adc_ctrl.v]
// Our own choices: the register offsets and the strobed register port.
`include "acsc_defs.vh"
`default_nettype none

module acsc_adc_ctrl
(
  // clock and reset
  input wire ref_clk_in,
  input wire resetn_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // cpu sleep and interrupt
  input wire cpu_halted_in,
  input wire [2:0] sleep_mode_in,
  input wire vector_ack_in,
  output reg conv_irq_out,
  output reg irq_out,
  // analog front end
  input wire comp_in,
  output reg adc_power_out,
  output reg sample_out,
  output reg [9:0] dac_code_out,
  output reg [3:0] channel_out,
  output reg [1:0] reference_out,
  output reg temp_sensor_en_out
);

  // prescaler division factor from select code
  function [7:0] div_of;
    input [2:0] ps;
    begin
      case (ps)
        3'h0: div_of = 8'h02;
        3'h1: div_of = 8'h02;
        3'h2: div_of = 8'h04;
        3'h3: div_of = 8'h08;
        3'h4: div_of = 8'h10;
        3'h5: div_of = 8'h20;
        3'h6: div_of = 8'h40;
        default: div_of = 8'h80;
      endcase
    end
  endfunction

  // control state
  reg en_q;
  reg ie_q;
  reg [2:0] ps_q;
  reg done_q;
  reg [7:0] sel_q;
  reg busy_q;
  reg first_q;
  reg [4:0] cyc_q;
  reg [9:0] trial_q;
  reg [9:0] res_q;
  reg lock_q;
  reg [2:0] st_q;
  reg [2:0] msk_q;
  reg [7:0] pre_q;
  reg halt_prev_q;
  reg comp_s1_q;
  reg comp_s2_q;
  reg [3:0] eff_ch_q;
  reg [1:0] eff_ref_q;

  wire wr_ctrl = reg_wr_in && (reg_addr_in == `ACSC_OFS_CTRL);
  wire wr_sel = reg_wr_in && (reg_addr_in == `ACSC_OFS_SEL);
  wire wr_st = reg_wr_in && (reg_addr_in == `ACSC_OFS_IRQ_ST);
  wire wr_msk = reg_wr_in && (reg_addr_in == `ACSC_OFS_IRQ_MSK);
  wire rd_lo = reg_rd_in && (reg_addr_in == `ACSC_OFS_RES_LO);
  wire rd_hi = reg_rd_in && (reg_addr_in == `ACSC_OFS_RES_HI);

  // converter clock enable
  wire [7:0] div = div_of(ps_q);
  wire tick = en_q && (pre_q == div - 8'h01);

  wire en_d = wr_ctrl ? reg_wdata_in[`ACSC_CTRL_EN] : en_q;
  wire abort = busy_q && !en_d;

  // new sleep only on halt rising edge
  wire halt_rise = cpu_halted_in && !halt_prev_q;
  wire sleep_ok = (sleep_mode_in == `ACSC_SLP_IDLE) || (sleep_mode_in == `ACSC_SLP_NOISE);
  wire sleep_start = halt_rise && sleep_ok && en_q && !busy_q;
  wire sw_start = wr_ctrl && reg_wdata_in[`ACSC_CTRL_START] && en_d && !busy_q;
  wire start = sleep_start || sw_start;

  // conversion phase decode
  wire [4:0] len = first_q ? `ACSC_FIRST_CYC : `ACSC_NORM_CYC;
  wire [4:0] kpos = len - 5'h02 - cyc_q;
  wire in_bits = (cyc_q >= len - 5'h0b) && (cyc_q <= len - 5'h02);
  wire last = busy_q && tick && (cyc_q == len - 5'h01);
  wire [9:0] kmask = 10'h001 << kpos[3:0];
  // keep or drop trial bit per comparator
  wire [9:0] kept = comp_s2_q ? trial_q : (trial_q & ~kmask);
  wire [9:0] next_trial = (kpos == 5'h00) ? kept : (kept | (kmask >> 1));
  wire finish = last && !lock_q;

  // comparator synchroniser
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
    end
    else
    begin
      comp_s1_q <= comp_in;
      comp_s2_q <= comp_s1_q;
    end
  end

  // prescaler, held clear while disabled
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      pre_q <= 8'h00;
    else if (!en_q || tick)
      pre_q <= 8'h00;
    else
      pre_q <= pre_q + 8'h01;
  end

  // control and select registers
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      en_q <= 1'b0;
      ie_q <= 1'b0;
      ps_q <= 3'h0;
      sel_q <= `ACSC_RST_BYTE;
      msk_q <= `ACSC_RST_IRQ;
      halt_prev_q <= 1'b0;
    end
    else
    begin
      halt_prev_q <= cpu_halted_in;
      en_q <= en_d;
      if (wr_ctrl)
      begin
        ie_q <= reg_wdata_in[`ACSC_CTRL_IE];
        ps_q <= reg_wdata_in[`ACSC_CTRL_PS_HI:`ACSC_CTRL_PS_LO];
      end
      if (wr_sel)
        sel_q <= reg_wdata_in & 8'hef;
      if (wr_msk)
        msk_q <= reg_wdata_in[2:0];
    end
  end

  // conversion sequencer and successive approximation
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      busy_q <= 1'b0;
      first_q <= 1'b0;
      cyc_q <= 5'h00;
      trial_q <= 10'h000;
    end
    else
    begin
      if (en_d && !en_q)
        first_q <= 1'b1;
      if (abort)
        busy_q <= 1'b0;
      else if (start)
      begin
        busy_q <= 1'b1;
        cyc_q <= 5'h00;
        trial_q <= 10'h200;
      end
      else if (busy_q && tick)
      begin
        if (last)
        begin
          busy_q <= 1'b0;
          first_q <= 1'b0;
        end
        else
          cyc_q <= cyc_q + 5'h01;
        if (in_bits)
          trial_q <= next_trial;
      end
    end
  end

  // result, lock and done flag
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      res_q <= 10'h000;
      lock_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      if (finish)
        res_q <= trial_q;
      // low read locks, high read frees
      if (rd_lo)
        lock_q <= 1'b1;
      else if (rd_hi)
        lock_q <= 1'b0;
      // set wins over ack or W1C
      if (finish)
        done_q <= 1'b1;
      else if (vector_ack_in || (wr_ctrl && reg_wdata_in[`ACSC_CTRL_DONE]))
        done_q <= 1'b0;
    end
  end

  // sticky interrupt status, write one clears
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      st_q <= `ACSC_RST_IRQ;
    else
    begin
      st_q[`ACSC_IRQ_DONE] <= finish ||
        (st_q[`ACSC_IRQ_DONE] && !(wr_st && reg_wdata_in[`ACSC_IRQ_DONE]));
      st_q[`ACSC_IRQ_SLEEP] <= sleep_start ||
        (st_q[`ACSC_IRQ_SLEEP] && !(wr_st && reg_wdata_in[`ACSC_IRQ_SLEEP]));
      st_q[`ACSC_IRQ_ABORT] <= abort ||
        (st_q[`ACSC_IRQ_ABORT] && !(wr_st && reg_wdata_in[`ACSC_IRQ_ABORT]));
    end
  end

  // selection follows register while idle, locked in conversion
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      eff_ch_q <= 4'h0;
      eff_ref_q <= 2'h0;
    end
    else if (!busy_q || last)
    begin
      eff_ch_q <= sel_q[`ACSC_SEL_CH_HI:`ACSC_SEL_CH_LO];
      eff_ref_q <= sel_q[`ACSC_SEL_REF_HI:`ACSC_SEL_REF_LO];
    end
  end

  // read data one cycle after the strobe
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `ACSC_OFS_RES_LO:
          reg_rdata_out <= sel_q[`ACSC_SEL_LADJ] ? {res_q[1:0], 6'h00} : res_q[7:0];
        `ACSC_OFS_RES_HI:
          reg_rdata_out <= sel_q[`ACSC_SEL_LADJ] ? res_q[9:2] : {6'h00, res_q[9:8]};
        `ACSC_OFS_CTRL:
          reg_rdata_out <= {en_q, busy_q, 1'b0, done_q, ie_q, ps_q};
        `ACSC_OFS_SEL:
          reg_rdata_out <= sel_q;
        `ACSC_OFS_IRQ_ST:
          reg_rdata_out <= {5'h00, st_q};
        `ACSC_OFS_IRQ_MSK:
          reg_rdata_out <= {5'h00, msk_q};
        default:
          reg_rdata_out <= 8'h00;
      endcase
    end
    else
      reg_rdata_out <= 8'h00;
  end

  // interrupt lines and analog controls
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      conv_irq_out <= 1'b0;
      irq_out <= 1'b0;
      adc_power_out <= 1'b0;
      sample_out <= 1'b0;
      dac_code_out <= 10'h000;
      channel_out <= 4'h0;
      reference_out <= 2'h0;
      temp_sensor_en_out <= 1'b0;
    end
    else
    begin
      conv_irq_out <= done_q && ie_q;
      irq_out <= |(st_q & msk_q);
      adc_power_out <= en_q;
      sample_out <= busy_q && (cyc_q < len - 5'h0b);
      dac_code_out <= trial_q;
      channel_out <= eff_ch_q;
      reference_out <= eff_ref_q;
      temp_sensor_en_out <= (sel_q[`ACSC_SEL_CH_HI:`ACSC_SEL_CH_LO] == `ACSC_CH_TEMP);
    end
  end

endmodule // acsc_adc_ctrl

`default_nettype wire

// [pkg/acsc_defs.vh]
`ifndef ACSC_DEFS_VH
`define ACSC_DEFS_VH

// register offsets
`define ACSC_OFS_RES_LO 8'h78
`define ACSC_OFS_RES_HI 8'h79
`define ACSC_OFS_CTRL 8'h7a
`define ACSC_OFS_SEL 8'h7c
`define ACSC_OFS_IRQ_ST 8'h7d
`define ACSC_OFS_IRQ_MSK 8'h7e

// control register fields
`define ACSC_CTRL_EN 7
`define ACSC_CTRL_START 6
`define ACSC_CTRL_DONE 4
`define ACSC_CTRL_IE 3
`define ACSC_CTRL_PS_HI 2
`define ACSC_CTRL_PS_LO 0

// input select register fields
`define ACSC_SEL_REF_HI 7
`define ACSC_SEL_REF_LO 6
`define ACSC_SEL_LADJ 5
`define ACSC_SEL_CH_HI 3
`define ACSC_SEL_CH_LO 0

// channel and reference codes
`define ACSC_CH_TEMP 4'h8
`define ACSC_REF_PIN 2'h0
`define ACSC_REF_SUPPLY 2'h1
`define ACSC_REF_INT 2'h3

// interrupt status bits
`define ACSC_IRQ_DONE 0
`define ACSC_IRQ_SLEEP 1
`define ACSC_IRQ_ABORT 2

// sleep mode codes
`define ACSC_SLP_IDLE 3'h0
`define ACSC_SLP_NOISE 3'h1

// reset values
`define ACSC_RST_BYTE 8'h00
`define ACSC_RST_IRQ 3'h0

// conversion lengths in converter clock cycles
`define ACSC_NORM_CYC 5'h0d
`define ACSC_FIRST_CYC 5'h19

`endif

// [sim/acsc_afe_model.sv]
`default_nettype none
// comparator stand-in for the analog front end
module acsc_afe_model (
  input wire logic ref_clk_in,
  input wire logic [9:0] dac_code_out,
  input wire logic [9:0] vin_code,
  output var logic comp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] dly_q = 2'h0;
  initial comp_in = 1'b0;
  // input steady, settles in three clocks
  always @(posedge ref_clk_in)
  begin
    dly_q <= {dly_q[0], vin_code >= dac_code_out};
    comp_in <= dly_q[1];
  end
endmodule // acsc_afe_model
`default_nettype wire

// [sim/acsc_adc_ctrl_asserts.sv]
`default_nettype none
module acsc_chk (
  // watched ports
  input wire ref_clk_in,
  input wire resetn_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire cpu_halted_in,
  input wire [2:0] sleep_mode_in,
  input wire vector_ack_in,
  input wire conv_irq_out,
  input wire adc_power_out,
  input wire sample_out,
  input wire temp_sensor_en_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  wire ctl_wr = reg_wr_in && reg_addr_in == 8'h7a;
  sequence s_halt;
    !cpu_halted_in ##1 cpu_halted_in;
  endsequence
  property p_start;
    s_halt ##0 sleep_mode_in < 3'h2 && adc_power_out && !$past(reg_wr_in)
      |-> ##[1:2] sample_out;
  endproperty
  a_start: assert property (p_start) else $error("no sleep start");
  property p_dis;
    s_halt ##0 !adc_power_out && !reg_wr_in && !$past(reg_wr_in) |-> ##2 !sample_out;
  endproperty
  a_dis: assert property (p_dis) else $error("start while off");
  property p_deep;
    cpu_halted_in && adc_power_out && !reg_wr_in && !$past(reg_wr_in) |=> adc_power_out;
  endproperty
  a_deep: assert property (p_deep) else $error("power dropped in sleep");
  property p_off;
    ctl_wr && !reg_wdata_in[7] |=> ##1 !adc_power_out && !sample_out;
  endproperty
  a_off: assert property (p_off) else $error("abort missing");
  property p_hold;
    conv_irq_out && !vector_ack_in && !ctl_wr && !$past(vector_ack_in) && !$past(ctl_wr)
      |=> conv_irq_out;
  endproperty
  a_hold: assert property (p_hold) else $error("request lost");
  property p_ack;
    vector_ack_in && !sample_out |=> ##1 !conv_irq_out;
  endproperty
  a_ack: assert property (p_ack) else $error("ack kept flag");
  property p_temp;
    reg_wr_in && reg_addr_in == 8'h7c |=>
      ##1 temp_sensor_en_out == ($past(reg_wdata_in[3:0], 2) == 4'h8);
  endproperty
  a_temp: assert property (p_temp) else $error("sensor enable wrong");
  property p_rd0;
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
  endproperty
  a_rd0: assert property (p_rd0) else $error("read data not idle");
endmodule // acsc_chk
bind acsc_adc_ctrl acsc_chk chk_u (.ref_clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cpu_halted_in, .sleep_mode_in, .vector_ack_in,
  .conv_irq_out, .adc_power_out, .sample_out, .temp_sensor_en_out);
`default_nettype wire

// [sim/acsc_adc_ctrl_tb.sv]
`default_nettype none
module acsc_adc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 0, resetn_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic cpu_halted_in = 0, vector_ack_in = 0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  logic [2:0] sleep_mode_in = 3'h0;
  logic [9:0] vin = 10'h2a5;
  wire [7:0] reg_rdata_out;
  wire [9:0] dac_code_out;
  wire [3:0] channel_out;
  wire [1:0] reference_out;
  wire conv_irq_out, irq_out, comp_in, adc_power_out, sample_out, temp_sensor_en_out;
  int failures = 0, checked = 0, cyc = 0;
  acsc_adc_ctrl dut_u (.ref_clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .cpu_halted_in, .sleep_mode_in, .vector_ack_in,
    .conv_irq_out, .irq_out, .comp_in, .adc_power_out, .sample_out, .dac_code_out,
    .channel_out, .reference_out, .temp_sensor_en_out);
  acsc_afe_model afe_u (.ref_clk_in, .dac_code_out, .vin_code(vin), .comp_in);
  // clock
  initial
  begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(nm, e, reg_rdata_out);
  endtask
  task automatic halt(input logic [2:0] m);
    @(posedge ref_clk_in);
    cpu_halted_in <= 1'b0;
    @(posedge ref_clk_in);
    sleep_mode_in <= m;
    cpu_halted_in <= 1'b1;
  endtask
  task automatic wait_irq(input int n);
    repeat (n)
      if (conv_irq_out !== 1'b1)
      begin
        @(posedge ref_clk_in);
        #1;
      end
    chk("conv_irq", 1, conv_irq_out);
  endtask
  task t_regs;
    rd(8'h7a, 8'h00, "ctrl reset");
    wr(8'h50, 8'hff);
    rd(8'h50, 8'h00, "unmapped");
    wr(8'h7c, 8'hd8);
    rd(8'h7c, 8'hc8, "sel");
    chk("ref", 2'h3, reference_out);
    chk("chan", 4'h8, channel_out);
    chk("temp_en", 1, temp_sensor_en_out);
    $display("test regs done");
  endtask
  task t_sleep;
    wr(8'h7a, 8'h8b);
    wr(8'h7e, 8'h01);
    halt(3'h1);
    wait_irq(400);
    chk("dac", vin, dac_code_out);
    chk("irq", 1, irq_out);
    rd(8'h7a, 8'h9b, "ctrl done");
    rd(8'h78, vin[7:0], "res_lo");
    rd(8'h79, {6'h0, vin[9:8]}, "res_hi");
    @(posedge ref_clk_in);
    cpu_halted_in <= 1'b0;
    vector_ack_in <= 1'b1;
    @(posedge ref_clk_in);
    vector_ack_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1 chk("ack", 0, conv_irq_out);
    wr(8'h7d, 8'h07);
    @(posedge ref_clk_in);
    #1 chk("irq w1c", 0, irq_out);
    $display("test sleep done");
  endtask
  task t_wake;
    vin <= 10'h15a;
    halt(3'h0);
    repeat (20) @(posedge ref_clk_in);
    cpu_halted_in <= 1'b0;
    wait_irq(400);
    rd(8'h78, 8'h5a, "lo2");
    rd(8'h79, 8'h01, "hi2");
    rd(8'h7a, 8'h9b, "no restart");
    wr(8'h7a, 8'h9b);
    wr(8'h7d, 8'h07);
    $display("test wake done");
  endtask
  task t_lock;
    rd(8'h78, 8'h5a, "lo lock");
    vin <= 10'h0f0;
    wr(8'h7a, 8'hcb);
    repeat (200) @(posedge ref_clk_in);
    #1 chk("lock irq", 0, conv_irq_out);
    rd(8'h7a, 8'h8b, "lock done");
    rd(8'h79, 8'h01, "hi kept");
    wr(8'h7c, 8'he8);
    rd(8'h79, 8'h56, "hi ladj");
    rd(8'h78, 8'h80, "lo ladj");
    rd(8'h79, 8'h56, "hi free");
    $display("test lock done");
  endtask
  task t_deep;
    halt(3'h2);
    repeat (50) @(posedge ref_clk_in);
    #1 chk("power deep", 1, adc_power_out);
    rd(8'h7a, 8'h8b, "deep idle");
    halt(3'h1);
    repeat (10) @(posedge ref_clk_in);
    wr(8'h7a, 8'h0b);
    repeat (300) @(posedge ref_clk_in);
    #1 chk("abort", 0, conv_irq_out);
    rd(8'h7a, 8'h0b, "off idle");
    rd(8'h7d, 8'h06, "status");
    halt(3'h1);
    repeat (300) @(posedge ref_clk_in);
    #1 chk("off start", 0, conv_irq_out);
    rd(8'h7a, 8'h0b, "off busy");
    $display("test deep done");
  endtask
  task report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // run limit
  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (16) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    t_regs;
    t_sleep;
    t_wake;
    t_lock;
    t_deep;
    report_and_stop;
  end
endmodule // acsc_adc_ctrl_tb
`default_nettype wire
